// >>> design/hde_core.sv
`timescale 1ns/100ps
module hde_core
  import hde_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             IRQ,
  output logic             DMA_REQ
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  hde_state_t  s_q;
  hde_state_t  s_d;
  logic [4:0]  aw_idx;
  logic [4:0]  ar_idx;
  logic        busy;
  logic        wr_ok;
  logic        stall;
  logic        wr_go;
  logic        ar_go;
  logic [6:0]  nr;
  int          nwd;
  logic [31:0] din;
  logic [31:0] rd;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] c;
  logic [31:0] d;
  logic [31:0] e;
  logic [31:0] f1;
  logic [31:0] t1;
  logic [31:0] t2;
  logic [31:0] s1_new;
  logic [31:0] s256_new;
  logic [31:0] md_f;
  logic [31:0] md_tmp;
  logic [3:0]  md_g;
  logic [1:0]  k1_sel;

  // ------------------------------------------------------------
  // Algorithm shape: rounds per block and digest word count
  // ------------------------------------------------------------
  assign busy = s_q.fsm != FSM_IDLE;
  assign nr   = (s_q.algo == A_SHA1) ? NR_SHA1 : NR_64;
  always_comb begin
    case (s_q.algo)
      A_SHA1:   nwd = 5;
      A_MD5:    nwd = 4;
      A_SHA224: nwd = 7;
      default:  nwd = 8;
    endcase
  end

  // Input word: swap, then key pad for the keyed mode
  always_comb begin
    case (s_q.swp)
      W_NONE:  din = S_AXI_WDATA;
      W_HALF:  din = {S_AXI_WDATA[15:0], S_AXI_WDATA[31:16]};
      W_BYTE:  din = hde_bswap(S_AXI_WDATA);
      default: din = {<<{S_AXI_WDATA}};
    endcase
    case (s_q.hph)
      2'h1:    din = din ^ HDE_IPAD;
      2'h2:    din = din ^ HDE_OPAD;
      default: din = din;
    endcase
  end

  // ------------------------------------------------------------
  // Round datapaths, all driven by the working registers
  // ------------------------------------------------------------
  assign a = s_q.v[0];
  assign b = s_q.v[1];
  assign c = s_q.v[2];
  assign d = s_q.v[3];
  assign e = s_q.v[4];
  // SHA-1 round function and schedule
  assign k1_sel = (s_q.rnd < 7'h14) ? 2'h0 : (s_q.rnd < 7'h28) ? 2'h1 :
                  (s_q.rnd < 7'h3c) ? 2'h2 : 2'h3;
  always_comb begin
    case (k1_sel)
      2'h0:    f1 = (b & c) | (~b & d);
      2'h2:    f1 = (b & c) | (b & d) | (c & d);
      default: f1 = b ^ c ^ d;
    endcase
  end
  assign s1_new = hde_ror(s_q.w[13] ^ s_q.w[8] ^ s_q.w[2] ^ s_q.w[0], 31);
  // SHA-256 round function and schedule; SHA-224 shares it
  assign t1 = s_q.v[7] + (hde_ror(e, 6) ^ hde_ror(e, 11) ^ hde_ror(e, 25)) +
              ((e & s_q.v[5]) ^ (~e & s_q.v[6])) + HDE_K256[s_q.rnd[5:0]] + s_q.w[0];
  assign t2 = (hde_ror(a, 2) ^ hde_ror(a, 13) ^ hde_ror(a, 22)) +
              ((a & b) ^ (a & c) ^ (b & c));
  assign s256_new = (hde_ror(s_q.w[14], 17) ^ hde_ror(s_q.w[14], 19) ^ (s_q.w[14] >> 10)) +
                    s_q.w[9] + s_q.w[0] +
                    (hde_ror(s_q.w[1], 7) ^ hde_ror(s_q.w[1], 18) ^ (s_q.w[1] >> 3));
  // MD5 keeps the buffer still and indexes it per round
  always_comb begin
    case (s_q.rnd[5:4])
      2'h0: begin
        md_f = (b & c) | (~b & d);
        md_g = s_q.rnd[3:0];
      end
      2'h1: begin
        md_f = (d & b) | (~d & c);
        md_g = 4'(5 * s_q.rnd[3:0] + 1);
      end
      2'h2: begin
        md_f = b ^ c ^ d;
        md_g = 4'(3 * s_q.rnd[3:0] + 5);
      end
      default: begin
        md_f = c ^ (b | ~d);
        md_g = 4'(7 * s_q.rnd[3:0]);
      end
    endcase
  end
  // Buffer holds SHA byte order; MD5 reads its words byte reversed
  assign md_tmp = a + md_f + HDE_MD5_T[s_q.rnd[5:0]] + hde_bswap(s_q.w[md_g]);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign aw_idx = S_AXI_AWADDR[6:2];
  assign ar_idx = S_AXI_ARADDR[6:2];
  assign wr_ok  = (S_AXI_WSTRB == 4'hf) && !S_AXI_AWADDR[7];
  // Data and R_STR writes wait while a block runs, final or not; errors never wait
  assign stall  = busy && wr_ok && (aw_idx == R_DIN || aw_idx == R_STR);
  assign wr_go  = S_AXI_AWVALID && S_AXI_WVALID && !s_q.bvalid && !stall;
  assign ar_go  = S_AXI_ARVALID && !s_q.rvalid;

  // Read mux; unused digest words read as zero
  always_comb begin
    rd = '0;
    if (ar_idx[4]) begin
      rd = s_q.w[ar_idx[3:0]];
    end else if (ar_idx[3]) begin
      if (int'(ar_idx[2:0]) < nwd) rd = s_q.h[ar_idx[2:0]];
    end else begin
      case (ar_idx)
        R_CTRL:  rd = {25'h0, s_q.dma_en, s_q.hph, s_q.swp, s_q.algo};
        R_STR:   rd = {27'h0, s_q.nb};
        R_IMR:   rd = {30'h0, s_q.imr};
        R_SR:    rd = {28'h0, DMA_REQ, busy, s_q.sr};
        R_CNT:   rd = {27'h0, s_q.cnt};
        R_LENLO: rd = s_q.len[31:0];
        R_LENHI: rd = s_q.len[63:32];
        default: rd = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Bus handshakes
    if (s_q.bvalid && S_AXI_BREADY) s_d.bvalid = 1'h0;
    if (s_q.rvalid && S_AXI_RREADY) s_d.rvalid = 1'h0;
    if (ar_go) begin
      s_d.rvalid = 1'h1;
      s_d.rdata  = S_AXI_ARADDR[7] ? '0 : rd;
      s_d.rresp  = S_AXI_ARADDR[7] ? RESP_ERR : RESP_OK;
      // Reading status clears the sticky bits; later sets win
      if (!S_AXI_ARADDR[7] && ar_idx == R_SR) s_d.sr = '0;
    end
    if (wr_go) begin
      s_d.bvalid = 1'h1;
      s_d.bresp  = wr_ok ? RESP_OK : RESP_ERR;
    end
    // Register writes; everything but the mask is frozen while busy
    if (wr_go && wr_ok && aw_idx == R_IMR) s_d.imr = S_AXI_WDATA[1:0];
    if (wr_go && wr_ok && !busy) begin
      if (aw_idx[4]) begin
        s_d.w[aw_idx[3:0]] = S_AXI_WDATA;
      end else if (aw_idx[3]) begin
        s_d.h[aw_idx[2:0]] = S_AXI_WDATA;
      end else begin
        case (aw_idx)
          R_CTRL: begin
            s_d.algo   = S_AXI_WDATA[C_ALGO+:2];
            s_d.swp    = S_AXI_WDATA[C_SWP+:2];
            s_d.hph    = S_AXI_WDATA[C_HPH+:2];
            s_d.dma_en = S_AXI_WDATA[C_DMA];
            if (S_AXI_WDATA[C_INIT]) begin
              s_d.h        = HDE_IV[S_AXI_WDATA[C_ALGO+:2]];
              s_d.cnt      = '0;
              s_d.len      = '0;
              s_d.nb       = '0;
              s_d.marked   = 1'h0;
              s_d.pad_mode = 1'h0;
              s_d.last     = 1'h0;
            end
          end
          R_DIN: begin
            // A word announced as partial gets its end marker here
            if (s_q.nb != 5'h00) begin
              s_d.w[s_q.cnt[3:0]] = (din & ~(32'hffff_ffff >> s_q.nb)) |
                                    (HDE_MARK >> s_q.nb);
              s_d.len    = s_q.len + 64'(s_q.nb);
              s_d.marked = 1'h1;
              s_d.nb     = '0;
            end else begin
              s_d.w[s_q.cnt[3:0]] = din;
              s_d.len = s_q.len + 64'h20;
            end
            s_d.cnt = s_q.cnt + 5'h01;
            if (s_q.cnt == 5'h0f) s_d.fsm = FSM_LOAD;
          end
          R_STR: begin
            s_d.nb = S_AXI_WDATA[4:0];
            if (S_AXI_WDATA[C_FIN]) begin
              s_d.pad_mode = 1'h1;
              s_d.pad_one  = !s_q.marked;
              s_d.fsm      = FSM_PAD;
            end
          end
          R_CNT:   s_d.cnt = S_AXI_WDATA[4:0];
          R_LENLO: s_d.len[31:0] = S_AXI_WDATA;
          R_LENHI: s_d.len[63:32] = S_AXI_WDATA;
          default: s_d.cnt = s_q.cnt;
        endcase
      end
    end
    // Engine
    case (s_q.fsm)
      FSM_IDLE: s_d.rnd = '0;
      FSM_LOAD: begin
        s_d.v   = s_q.h;
        s_d.rnd = '0;
        s_d.fsm = FSM_RND;
      end
      FSM_RND: begin
        case (s_q.algo)
          A_SHA1: begin
            s_d.v[4:0] = {d, c, hde_ror(b, 2),
                          a, hde_ror(a, 27) + f1 + e + HDE_K1[k1_sel] + s_q.w[0]};
            s_d.w = {s1_new, s_q.w[15:1]};
          end
          A_MD5: s_d.v[3:0] = {c, b, b + hde_ror(md_tmp,
                               32 - HDE_MD5_S[{s_q.rnd[5:4], s_q.rnd[1:0]}]), d};
          default: begin
            s_d.v = {s_q.v[6:4], d + t1, c, b, a, t1 + t2};
            s_d.w = {s256_new, s_q.w[15:1]};
          end
        endcase
        s_d.rnd = s_q.rnd + 7'h01;
        if (s_q.rnd == nr - 7'h01) s_d.fsm = FSM_ADD;
      end
      FSM_ADD: begin
        // SHA-224 runs all eight words; only its readout is cut to seven
        for (int i = 0; i < 8; i++) begin
          if (i < nwd || s_q.algo == A_SHA224) s_d.h[i] = s_q.h[i] + s_q.v[i];
        end
        s_d.cnt = '0;
        if (s_q.last) begin
          s_d.fsm         = FSM_IDLE;
          s_d.sr[SR_DONE] = 1'h1;
          s_d.pad_mode    = 1'h0;
          s_d.last        = 1'h0;
          s_d.marked      = 1'h0;
        end else if (s_q.pad_mode) begin
          s_d.fsm = FSM_PAD;
        end else begin
          s_d.fsm        = FSM_IDLE;
          s_d.sr[SR_BLK] = 1'h1;
        end
      end
      FSM_PAD: begin
        // One padding word per cycle; length words go in together
        if (s_q.cnt == 5'h10) begin
          s_d.fsm = FSM_LOAD;
        end else if (s_q.pad_one) begin
          s_d.w[s_q.cnt[3:0]] = HDE_MARK;
          s_d.pad_one = 1'h0;
          s_d.cnt     = s_q.cnt + 5'h01;
        end else if (s_q.cnt == 5'h0e) begin
          if (s_q.algo == A_MD5) begin
            s_d.w[15:14] = {hde_bswap(s_q.len[63:32]), hde_bswap(s_q.len[31:0])};
          end else begin
            s_d.w[15:14] = {s_q.len[31:0], s_q.len[63:32]};
          end
          s_d.cnt  = 5'h10;
          s_d.last = 1'h1;
        end else begin
          s_d.w[s_q.cnt[3:0]] = '0;
          s_d.cnt = s_q.cnt + 5'h01;
        end
      end
      default: s_d.fsm = FSM_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY  = wr_go;
  assign S_AXI_BVALID  = s_q.bvalid;
  assign S_AXI_BRESP   = s_q.bresp;
  assign S_AXI_ARREADY = !s_q.rvalid;
  assign S_AXI_RVALID  = s_q.rvalid;
  assign S_AXI_RRESP   = s_q.rresp;
  assign S_AXI_RDATA   = s_q.rdata;
  assign IRQ           = |(s_q.sr & s_q.imr);
  // Room for a burst of four keeps bursts from ever stalling
  assign DMA_REQ = s_q.dma_en && !busy && !s_q.pad_mode && (s_q.cnt <= 5'h0c);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  sha1_time_a: assert property ((s_q.fsm == FSM_LOAD && s_q.algo == A_SHA1) |-> ##81
    s_q.fsm == FSM_ADD) else $error("SHA-1 block not 82 cycles");
  sha256_time_a: assert property ((s_q.fsm == FSM_LOAD && s_q.algo[1]) |-> ##65
    s_q.fsm == FSM_ADD) else $error("SHA-256 block not 66 cycles");
  md5_time_a: assert property ((s_q.fsm == FSM_LOAD && s_q.algo == A_MD5) |-> ##65
    s_q.fsm == FSM_ADD) else $error("MD5 block not 66 cycles");
  word_err_a: assert property ((wr_go && S_AXI_WSTRB != 4'hf) |=>
    (S_AXI_BVALID && S_AXI_BRESP == RESP_ERR)) else $error("partial write not refused");
  din_stall_a: assert property ((busy && wr_ok && aw_idx == R_DIN) |-> !S_AXI_AWREADY)
    else $error("data write taken while busy");
  digest_add_a: assert property ((s_q.fsm == FSM_ADD) |=>
    s_q.h[0] == $past(s_q.h[0] + s_q.v[0])) else $error("digest not accumulated");
  done_flag_a: assert property ((s_q.fsm == FSM_ADD && s_q.last) |=>
    (s_q.sr[SR_DONE] && !busy)) else $error("done flag missing");
  len_step_a: assert property ((wr_go && wr_ok && aw_idx == R_DIN && s_q.nb == 5'h00) |=>
    s_q.len == $past(s_q.len) + 64'h20) else $error("length not advanced by 32");
  len_words_a: assert property ((s_q.fsm == FSM_PAD && s_q.cnt == 5'h0e && !s_q.pad_one)
    |=> (s_q.cnt == 5'h10 && s_q.last) ##1 s_q.fsm == FSM_LOAD)
    else $error("length words not closing block");
  dma_room_a: assert property (DMA_REQ |-> (s_q.cnt <= 5'h0c && !busy))
    else $error("request without room for a burst");

  cover property (s_q.fsm == FSM_ADD && s_q.algo == A_SHA1);
  cover property (s_q.fsm == FSM_ADD && s_q.algo == A_MD5 && s_q.last);
  cover property (stall && S_AXI_AWVALID && S_AXI_WVALID);
  cover property (DMA_REQ ##1 !DMA_REQ);

endmodule

// >>> design/hde_pkg.sv
package hde_pkg;
  // --------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // --------------------------------------------------------------
  localparam logic [4:0] R_CTRL  = 5'h00;
  localparam logic [4:0] R_DIN   = 5'h01;
  localparam logic [4:0] R_STR   = 5'h02;
  localparam logic [4:0] R_IMR   = 5'h03;
  localparam logic [4:0] R_SR    = 5'h04;
  localparam logic [4:0] R_CNT   = 5'h05;
  localparam logic [4:0] R_LENLO = 5'h06;
  localparam logic [4:0] R_LENHI = 5'h07;
  // Digest words sit at 8..15, context words at 16..31

  // --------------------------------------------------------------
  // Field positions and codes
  // --------------------------------------------------------------
  localparam int C_ALGO = 0;
  localparam int C_SWP  = 2;
  localparam int C_HPH  = 4;
  localparam int C_DMA  = 6;
  localparam int C_INIT = 8;
  localparam int C_FIN  = 8;
  localparam int SR_BLK  = 0;
  localparam int SR_DONE = 1;
  localparam logic [1:0] A_SHA1   = 2'h0;
  localparam logic [1:0] A_MD5    = 2'h1;
  localparam logic [1:0] A_SHA224 = 2'h2;
  localparam logic [1:0] A_SHA256 = 2'h3;
  localparam logic [1:0] W_NONE = 2'h0;
  localparam logic [1:0] W_HALF = 2'h1;
  localparam logic [1:0] W_BYTE = 2'h2;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [6:0] NR_SHA1 = 7'h50;
  localparam logic [6:0] NR_64   = 7'h40;
  localparam logic [31:0] HDE_IPAD = 32'h3636_3636;
  localparam logic [31:0] HDE_OPAD = 32'h5c5c_5c5c;
  localparam logic [31:0] HDE_MARK = 32'h8000_0000;

  // --------------------------------------------------------------
  // Initial digests, indexed by algorithm code, word 0 lowest
  // --------------------------------------------------------------
  localparam logic [3:0][7:0][31:0] HDE_IV = {
    {32'h5be0_cd19, 32'h1f83_d9ab, 32'h9b05_688c, 32'h510e_527f,
     32'ha54f_f53a, 32'h3c6e_f372, 32'hbb67_ae85, 32'h6a09_e667},
    {32'hbefa_4fa4, 32'h64f9_8fa7, 32'h6858_1511, 32'hffc0_0b31,
     32'hf70e_5939, 32'h3070_dd17, 32'h367c_d507, 32'hc105_9ed8},
    {128'h0, 32'h1032_5476, 32'h98ba_dcfe, 32'hefcd_ab89, 32'h6745_2301},
    {96'h0, 32'hc3d2_e1f0, 32'h1032_5476, 32'h98ba_dcfe, 32'hefcd_ab89,
     32'h6745_2301}};
  localparam logic [3:0][31:0] HDE_K1 = {
    32'hca62_c1d6, 32'h8f1b_bcdc, 32'h6ed9_eba1, 32'h5a82_7999};
  localparam logic [31:0] HDE_K256 [64] = '{
    32'h428a_2f98, 32'h7137_4491, 32'hb5c0_fbcf, 32'he9b5_dba5, 32'h3956_c25b, 32'h59f1_11f1,
    32'h923f_82a4, 32'hab1c_5ed5, 32'hd807_aa98, 32'h1283_5b01, 32'h2431_85be, 32'h550c_7dc3,
    32'h72be_5d74, 32'h80de_b1fe, 32'h9bdc_06a7, 32'hc19b_f174, 32'he49b_69c1, 32'hefbe_4786,
    32'h0fc1_9dc6, 32'h240c_a1cc, 32'h2de9_2c6f, 32'h4a74_84aa, 32'h5cb0_a9dc, 32'h76f9_88da,
    32'h983e_5152, 32'ha831_c66d, 32'hb003_27c8, 32'hbf59_7fc7, 32'hc6e0_0bf3, 32'hd5a7_9147,
    32'h06ca_6351, 32'h1429_2967, 32'h27b7_0a85, 32'h2e1b_2138, 32'h4d2c_6dfc, 32'h5338_0d13,
    32'h650a_7354, 32'h766a_0abb, 32'h81c2_c92e, 32'h9272_2c85, 32'ha2bf_e8a1, 32'ha81a_664b,
    32'hc24b_8b70, 32'hc76c_51a3, 32'hd192_e819, 32'hd699_0624, 32'hf40e_3585, 32'h106a_a070,
    32'h19a4_c116, 32'h1e37_6c08, 32'h2748_774c, 32'h34b0_bcb5, 32'h391c_0cb3, 32'h4ed8_aa4a,
    32'h5b9c_ca4f, 32'h682e_6ff3, 32'h748f_82ee, 32'h78a5_636f, 32'h84c8_7814, 32'h8cc7_0208,
    32'h90be_fffa, 32'ha450_6ceb, 32'hbef9_a3f7, 32'hc671_78f2};
  localparam logic [31:0] HDE_MD5_T [64] = '{
    32'hd76a_a478, 32'he8c7_b756, 32'h2420_70db, 32'hc1bd_ceee, 32'hf57c_0faf, 32'h4787_c62a,
    32'ha830_4613, 32'hfd46_9501, 32'h6980_98d8, 32'h8b44_f7af, 32'hffff_5bb1, 32'h895c_d7be,
    32'h6b90_1122, 32'hfd98_7193, 32'ha679_438e, 32'h49b4_0821, 32'hf61e_2562, 32'hc040_b340,
    32'h265e_5a51, 32'he9b6_c7aa, 32'hd62f_105d, 32'h0244_1453, 32'hd8a1_e681, 32'he7d3_fbc8,
    32'h21e1_cde6, 32'hc337_07d6, 32'hf4d5_0d87, 32'h455a_14ed, 32'ha9e3_e905, 32'hfcef_a3f8,
    32'h676f_02d9, 32'h8d2a_4c8a, 32'hfffa_3942, 32'h8771_f681, 32'h6d9d_6122, 32'hfde5_380c,
    32'ha4be_ea44, 32'h4bde_cfa9, 32'hf6bb_4b60, 32'hbebf_bc70, 32'h289b_7ec6, 32'heaa1_27fa,
    32'hd4ef_3085, 32'h0488_1d05, 32'hd9d4_d039, 32'he6db_99e5, 32'h1fa2_7cf8, 32'hc4ac_5665,
    32'hf429_2244, 32'h432a_ff97, 32'hab94_23a7, 32'hfc93_a039, 32'h655b_59c3, 32'h8f0c_cc92,
    32'hffef_f47d, 32'h8584_5dd1, 32'h6fa8_7e4f, 32'hfe2c_e6e0, 32'ha301_4314, 32'h4e08_11a1,
    32'hf753_7e82, 32'hbd3a_f235, 32'h2ad7_d2bb, 32'heb86_d391};
  localparam int HDE_MD5_S [16] = '{7, 12, 17, 22, 5, 9, 14, 20, 4, 11, 16, 23, 6, 10, 15, 21};

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {FSM_IDLE, FSM_LOAD, FSM_RND, FSM_ADD, FSM_PAD} hde_fsm_t;
  typedef struct packed {
    hde_fsm_t          fsm;
    logic [1:0]        algo;
    logic [1:0]        swp;
    logic [1:0]        hph;
    logic              dma_en;
    logic [4:0]        nb;
    logic              marked;
    logic              pad_mode;
    logic              pad_one;
    logic              last;
    logic [4:0]        cnt;
    logic [6:0]        rnd;
    logic [63:0]       len;
    logic [15:0][31:0] w;
    logic [7:0][31:0]  h;
    logic [7:0][31:0]  v;
    logic [1:0]        sr;
    logic [1:0]        imr;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } hde_state_t;

  // Rotate right by a constant or table amount
  function automatic logic [31:0] hde_ror(input logic [31:0] x, input int n);
    return (x >> n) | (x << (32 - n));
  endfunction

  function automatic logic [31:0] hde_bswap(input logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
endpackage

// >>> tb/hde_axi_master.sv
`timescale 1ns/100ps
// ---------------------------------------
// Lite bus master standing for the processor or DMA side
// ---------------------------------------
module hde_axi_master
  import hde_pkg::*;
(
  input  wire logic        CORE_CLK,
  output logic [7:0]       S_AXI_AWADDR,
  output logic [7:0]       S_AXI_ARADDR,
  output logic [31:0]      S_AXI_WDATA,
  output logic [3:0]       S_AXI_WSTRB,
  output logic             S_AXI_AWVALID,
  output logic             S_AXI_WVALID,
  output logic             S_AXI_BREADY,
  output logic             S_AXI_ARVALID,
  output logic             S_AXI_RREADY,
  input  wire logic        S_AXI_AWREADY,
  input  wire logic        S_AXI_WREADY,
  input  wire logic        S_AXI_BVALID,
  input  wire logic        S_AXI_ARREADY,
  input  wire logic        S_AXI_RVALID
);
  // Expected answers: mask, response, data
  logic [65:0] exp_q[$];

  // Idle at time zero
  initial begin
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
  end

  // Released payload is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    exp_q.push_back({32'h0, r, 32'h0});
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    // Address and data are let go each at its own taking edge
    while (!(aw_ok && w_ok)) begin
      @(posedge CORE_CLK);
      if (!aw_ok && S_AXI_AWREADY) begin
        aw_ok = 1'b1;
        S_AXI_AWVALID <= 1'b0;
        S_AXI_AWADDR <= ~a;
      end
      if (!w_ok && S_AXI_WREADY) begin
        w_ok = 1'b1;
        S_AXI_WVALID <= 1'b0;
        S_AXI_WDATA <= ~d;
      end
    end
    do @(posedge CORE_CLK); while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
  endtask

  // Single word reads only, one outstanding
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    exp_q.push_back({m, r, d});
    @(posedge CORE_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge CORE_CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    S_AXI_ARADDR <= ~a;
    do @(posedge CORE_CLK); while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
  endtask
endmodule

// >>> tb/test_hash_digest_engine.sv
`timescale 1ns/100ps
module test_hash_digest_engine
  import hde_pkg::*;
;
  logic        CORE_CLK, ARST_N, IRQ, DMA_REQ;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, r;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [65:0] e;
  int          n_errors, n_compared;
  // Digest of "abc": word 0 and last word per algorithm code
  logic [31:0] w0 [4] = '{32'ha999_3e36, 32'h9850_0190, 32'h2309_7d22, 32'hba78_16bf};
  logic [31:0] wl [4] = '{32'h9cd0_d89d, 32'h727f_e128, 32'he36c_9da7, 32'hf200_15ad};
  int          nw [4] = '{5, 4, 7, 8};

  hde_core i_hde_core (.CORE_CLK, .ARST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .IRQ, .DMA_REQ);
  hde_axi_master i_hde_axi_master (.CORE_CLK, .S_AXI_AWADDR, .S_AXI_ARADDR, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_AWVALID, .S_AXI_WVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
    .S_AXI_RREADY, .S_AXI_AWREADY, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARREADY,
    .S_AXI_RVALID);

  always #25 CORE_CLK = ~CORE_CLK;

  function automatic logic [7:0] adr(input logic [4:0] i);
    return {1'b0, i, 2'b00};
  endfunction

  // Pre-swap the word so the engine's own swap restores it
  function automatic logic [31:0] swz(input int k, input logic [31:0] w);
    logic [31:0] b;
    for (int i = 0; i < 32; i++) b[i] = w[31-i];
    case (k)
      1: return {w[15:0], w[31:16]};
      2: return {w[7:0], w[15:8], w[23:16], w[31:24]};
      3: return b;
      default: return w;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Oldest note taken off at every answer handshake
  always @(posedge CORE_CLK) begin
    if ((S_AXI_BVALID && S_AXI_BREADY) || (S_AXI_RVALID && S_AXI_RREADY)) begin
      e = i_hde_axi_master.exp_q.pop_front();
      check({30'h0, S_AXI_BVALID ? S_AXI_BRESP : S_AXI_RRESP}, {30'h0, e[33:32]});
      check(S_AXI_RDATA & e[65:34], e[31:0]);
    end
  end

  // Watchdog: far beyond four short messages
  initial begin
    #(50 * 40000);
    n_errors++;
    final_report();
  end

  initial begin
    CORE_CLK = 1'b0;
    ARST_N = 1'b0;
    void'($urandom(32'ha538de19));
    repeat (8) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    // Sub-word and unmapped accesses are refused without effect
    i_hde_axi_master.wr(adr(R_CTRL), 32'h0000_0003, 4'h3, RESP_ERR);
    i_hde_axi_master.wr(8'h84, 32'h0, 4'hf, RESP_ERR);
    i_hde_axi_master.rd(8'h80, 32'h0, 32'hffff_ffff, RESP_ERR);
    i_hde_axi_master.rd(adr(R_CTRL), 32'h0, 32'hffff_ffff, RESP_OK);
    r = $urandom;
    i_hde_axi_master.wr(adr(R_IMR), r, 4'hf, RESP_OK);
    i_hde_axi_master.rd(adr(R_IMR), {30'h0, r[1:0]}, 32'hffff_ffff, RESP_OK);
    $display("test bus_access done");
    // Each algorithm paired with a different swap mode, padded one-word message
    for (int k = 0; k < 4; k++) begin
      i_hde_axi_master.wr(adr(R_CTRL), 32'h140 | 32'(k << 2) | 32'(k), 4'hf, RESP_OK);
      repeat (2) @(posedge CORE_CLK);
      check({31'h0, DMA_REQ}, 32'h1);
      i_hde_axi_master.wr(adr(R_IMR), 32'h2, 4'hf, RESP_OK);
      i_hde_axi_master.wr(adr(R_STR), 32'd24, 4'hf, RESP_OK);
      i_hde_axi_master.wr(adr(R_DIN), swz(k, 32'h6162_6300), 4'hf, RESP_OK);
      i_hde_axi_master.wr(adr(R_STR), 32'h100, 4'hf, RESP_OK);
      for (int t = 0; t < 2000 && IRQ !== 1'b1; t++) @(posedge CORE_CLK);
      check({31'h0, IRQ}, 32'h1);
      i_hde_axi_master.rd(adr(R_SR), 32'h2, 32'h2, RESP_OK);
      check({31'h0, IRQ}, 32'h0);
      i_hde_axi_master.rd(adr(5'd8), w0[k], 32'hffff_ffff, RESP_OK);
      i_hde_axi_master.rd(adr(5'(7 + nw[k])), wl[k], 32'hffff_ffff, RESP_OK);
      if (nw[k] < 8)
        i_hde_axi_master.rd(adr(5'(8 + nw[k])), 32'h0, 32'hffff_ffff, RESP_OK);
      $display("test digest_%0d done", k);
    end
    // Inner key pad lands in the buffer, count advances by one word
    i_hde_axi_master.wr(adr(R_CTRL), 32'h0000_0113, 4'hf, RESP_OK);
    r = $urandom;
    i_hde_axi_master.wr(adr(R_DIN), r, 4'hf, RESP_OK);
    i_hde_axi_master.rd(adr(5'd16), r ^ HDE_IPAD, 32'hffff_ffff, RESP_OK);
    i_hde_axi_master.rd(adr(R_CNT), 32'h1, 32'hffff_ffff, RESP_OK);
    $display("test key_pad done");
    // Saved context reloads into a digest word
    r = $urandom;
    i_hde_axi_master.wr(adr(5'd8), r, 4'hf, RESP_OK);
    i_hde_axi_master.rd(adr(5'd8), r, 32'hffff_ffff, RESP_OK);
    $display("test reload done");
    final_report();
  end
endmodule
